// *** rtl/voc_map.vh ***
// register map, field layout, reset values and timing for the output block
// What this block does
// - data pin drive field 0x14[5:4]: 01=2x, 10=3x reset, 11=4x, 00 reserved
// - pixel clock drive field 0x14[3:2]: same codes, 10 at reset
// - sync drive field 0x14[1:0] covers hsync, vertical and enable pins
// - 0x06[7] puts field (0) or vsync (1, reset) on vertical pin
// - 0x05[4] puts data enable (0, reset) or field (1) on enable pin
// - 0x06[0] inverts only the pixel clock pin, mode independent
// - 0x06[1] hsync negative when 0 (reset), positive when 1
// - 0x06[2] vertical pin negative when 0 (reset), positive when 1
// - 0x06[3] enable pin (data enable or field) positive when 0, negative when 1
// - video synth strips deep colour and repetition, locks within one frame
// - audio clock is link clock times N over CTS, locks within 5 ms
// - crystal select 0x04[2:1], reset 01
// - primary mode 0x01[3:0]: 0101 component, 0110 graphics at reset
// - video standard 0x00[5:0] resets to 000010, read with primary mode
// - front end decodes every stream; mode only steers later processing
// - in either mode video goes to component path, audio to audio port
`ifndef VOC_MAP_VH
`define VOC_MAP_VH
`define VOC_OFS_STD 8'h00
`define VOC_OFS_MODE 8'h01
`define VOC_OFS_XTAL 8'h04
`define VOC_OFS_FSEL 8'h05
`define VOC_OFS_POL 8'h06
`define VOC_OFS_DRV 8'h14
`define VOC_OFS_STAT 8'h6a
`define VOC_RST_STD 6'h02
`define VOC_RST_MODE 4'h6
`define VOC_RST_XTAL 2'h1
`define VOC_RST_FSEL 1'h0
`define VOC_RST_POL 5'h10
`define VOC_RST_DRV 2'h2
`define VOC_XTAL_LO 1
`define VOC_FSEL_BIT 4
`define VOC_POL_VSEL 7
`define VOC_DRV_DATA 4
`define VOC_DRV_CLK 2
`define VOC_DRV_SYNC 0
`define VOC_PIX_STEP 5'h08
`define VOC_AUD_LOCK_MS 5
`define VOC_CLK_KHZ 40000
`define VOC_AUD_SETTLE 5'h10
`define VOC_LOSS_CYC 9'h100
`endif

// *** rtl/voc_out_stage.v ***
// output pin stage: sync muxing, polarity and registered pins
`timescale 1ns/1ps
`default_nettype none
module voc_out_stage (
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire pix_in, // internal pixel clock level
	input wire hs_in, // hsync, active high
	input wire vs_in, // vsync, active high
	input wire field_in, // field flag
	input wire de_in, // data enable, active high
	input wire [4:0] pol, // {vsel, fpol, vpol, hpol, inv}
	input wire de_field_sel, // field onto enable pin
	output reg pixel_clock_out, // pixel clock pin
	output reg hsync_out, // hsync pin
	output reg vertical_sync_shared_pin, // vsync or field pin
	output reg de_out // enable or field pin
);
	wire vsrc = pol[4] ? vs_in : field_in;
	wire esrc = de_field_sel ? field_in : de_in;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pixel_clock_out <= 1'b0;
			hsync_out <= 1'b1;
			vertical_sync_shared_pin <= 1'b1;
			de_out <= 1'b0;
		end else begin
			pixel_clock_out <= pix_in ^ pol[0];
			hsync_out <= hs_in ^ ~pol[1];
			vertical_sync_shared_pin <= vsrc ^ ~pol[2];
			de_out <= esrc ^ pol[3];
		end
	end
endmodule // voc_out_stage
`default_nettype wire

// *** rtl/voc_i2c_slave.v ***
// serial register port slave with sub-address auto increment
`timescale 1ns/1ps
`default_nettype none
module voc_i2c_slave #(
	parameter [6:0] DEV_ADDR = 7'h4c // bus address, arbitrary
) (
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire scl_in, // serial clock pin
	input wire sda_in, // serial data pin in
	output wire sda_out, // serial data pin out
	output reg sda_oe, // pulls data low when high
	output reg [7:0] reg_addr, // register pointer
	input wire [7:0] rd_data, // data at pointer
	output reg [7:0] wr_addr, // write address
	output reg [7:0] wr_data, // write data
	output reg wr_en // write pulse
);
	localparam [6:0] S_IDLE = 7'h01, S_ADR = 7'h02, S_SUB = 7'h04;
	localparam [6:0] S_WR = 7'h08, S_AK = 7'h10, S_RD = 7'h20;
	localparam [6:0] S_MA = 7'h40;
	reg [2:0] scl_q, sda_q;
	reg [6:0] st, nxt;
	reg [7:0] sh;
	reg [3:0] cnt;
	wire scl = scl_q[1];
	wire sda = sda_q[1];
	wire rise = scl & ~scl_q[2];
	wire fall = ~scl & scl_q[2];
	wire start = scl & scl_q[2] & sda_q[2] & ~sda;
	wire stop = scl & scl_q[2] & ~sda_q[2] & sda;
	assign sda_out = 1'b0;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl_in};
			sda_q <= {sda_q[1:0], sda_in};
		end
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= S_IDLE;
			nxt <= S_IDLE;
			sh <= 8'h00;
			cnt <= 4'h0;
			sda_oe <= 1'b0;
			reg_addr <= 8'h00;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			wr_en <= 1'b0;
		end else begin
			wr_en <= 1'b0;
			if (start) begin
				st <= S_ADR;
				cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				st <= S_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st)
				S_ADR, S_SUB, S_WR: begin
					if (rise) begin
						sh <= {sh[6:0], sda};
						cnt <= cnt + 4'h1;
					end else if (fall && cnt == 4'h8) begin
						sda_oe <= 1'b1;
						st <= S_AK;
						if (st == S_ADR) begin
							nxt <= sh[0] ? S_RD : S_SUB;
							if (sh[7:1] != DEV_ADDR) begin
								sda_oe <= 1'b0;
								st <= S_IDLE;
							end
						end else if (st == S_SUB) begin
							reg_addr <= sh;
							nxt <= S_WR;
						end else begin
							wr_addr <= reg_addr;
							wr_data <= sh;
							wr_en <= 1'b1;
							reg_addr <= reg_addr + 8'h01;
							nxt <= S_WR;
						end
					end
				end
				S_AK, S_MA: begin
					if (rise && st == S_MA)
						nxt <= sda ? S_IDLE : S_RD;
					if (fall) begin
						cnt <= 4'h0;
						st <= nxt;
						sda_oe <= 1'b0;
						if (nxt == S_RD) begin
							sh <= rd_data;
							sda_oe <= ~rd_data[7];
						end
					end
				end
				S_RD: begin
					if (rise)
						cnt <= cnt + 4'h1;
					else if (fall && cnt == 4'h8) begin
						sda_oe <= 1'b0;
						st <= S_MA;
						reg_addr <= reg_addr + 8'h01;
					end else if (fall) begin
						sh <= {sh[6:0], 1'b0};
						sda_oe <= ~sh[6];
					end
				end
				S_IDLE: st <= S_IDLE;
				default: st <= S_IDLE;
				endcase
			end
		end
	end
endmodule // voc_i2c_slave
`default_nettype wire

// *** rtl/voc_top.v ***
// video output pin and mode configuration block with clock synthesis
`timescale 1ns/1ps
`default_nettype none
`include "voc_map.vh"
module voc_top #(
	parameter [6:0] DEV_ADDR = 7'h4c, // bus address, arbitrary
	parameter integer AUD_LOCK_CYC = `VOC_AUD_LOCK_MS * `VOC_CLK_KHZ,
	parameter integer VID_W = 24 // decoded pixel width
) (
	input wire clk, // 40 MHz system clock
	input wire rst_n, // async reset, active low
	input wire scl_in, // register port clock pin
	input wire sda_in, // register port data in
	output wire sda_out, // register port data out
	output wire sda_oe, // register port drive enable
	input wire link_clk_pin, // incoming link clock pin
	input wire [1:0] deep_color, // 0:8 1:10 2:12 3:16 bits
	input wire [3:0] pix_repeat, // repetition count minus one
	input wire [1:0] out_div, // datapath divide, log2
	input wire [19:0] acr_n, // audio N value
	input wire [19:0] acr_cts, // audio CTS value
	input wire acr_valid, // ACR packet pulse
	input wire [VID_W-1:0] dec_data, // decoded video
	input wire dec_valid, // decoded video valid
	input wire dec_hs, // decoded hsync, active high
	input wire dec_vs, // decoded vsync, active high
	input wire dec_field, // decoded field flag
	input wire dec_de, // decoded data enable
	input wire dec_audio, // decoded audio sample bit
	input wire dec_audio_valid, // decoded audio valid
	output reg [VID_W-1:0] component_processor_data, // decoded video out
	output reg component_processor_valid, // valid for video out
	output reg audio_out, // audio interface data
	output reg audio_out_valid, // audio interface valid
	output reg audio_mclk, // synthesized audio clock
	output wire pixel_clock_out, // pixel clock pin
	output wire hsync_out, // hsync pin
	output wire vertical_sync_shared_pin, // vsync or field pin
	output wire de_out, // enable or field pin
	output wire [1:0] data_drive_strength, // data pad drive
	output wire [1:0] clock_drive_strength, // clock pad drive
	output wire [1:0] sync_drive_strength, // sync pad drive
	output wire [1:0] crystal_frequency_select, // reference select
	output wire [3:0] primary_mode_select, // primary mode
	output wire [5:0] video_standard_select, // video standard
	output reg video_locked, // video synth locked
	output reg audio_locked // audio synth locked
);
	reg [5:0] std_r;
	reg [3:0] mode_r;
	reg [1:0] xtal_r;
	reg fsel_r;
	reg [4:0] pol_r;
	reg [5:0] drv_r;
	reg [7:0] rd_mux;
	wire [7:0] reg_addr, wr_addr, wr_data;
	wire wr_en;

	voc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.reg_addr(reg_addr),
		.rd_data(rd_mux),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_en(wr_en)
	);

	// coded fields stored as written; reserved codes are the host's problem
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			std_r <= `VOC_RST_STD;
			mode_r <= `VOC_RST_MODE;
			xtal_r <= `VOC_RST_XTAL;
			fsel_r <= `VOC_RST_FSEL;
			pol_r <= `VOC_RST_POL;
			drv_r <= {3{`VOC_RST_DRV}};
		end else if (wr_en) begin
			case (wr_addr)
			`VOC_OFS_STD: std_r <= wr_data[5:0];
			`VOC_OFS_MODE: mode_r <= wr_data[3:0];
			`VOC_OFS_XTAL: xtal_r <= wr_data[`VOC_XTAL_LO+:2];
			`VOC_OFS_FSEL: fsel_r <= wr_data[`VOC_FSEL_BIT];
			`VOC_OFS_POL: pol_r <= {wr_data[`VOC_POL_VSEL], wr_data[3:0]};
			`VOC_OFS_DRV: drv_r <= wr_data[5:0];
			default: drv_r <= drv_r;
			endcase
		end
	end

	always @* begin
		rd_mux = 8'h00;
		case (reg_addr)
		`VOC_OFS_STD: rd_mux = {2'h0, std_r};
		`VOC_OFS_MODE: rd_mux = {4'h0, mode_r};
		`VOC_OFS_XTAL: rd_mux = {5'h00, xtal_r, 1'b0};
		`VOC_OFS_FSEL: rd_mux = {3'h0, fsel_r, 4'h0};
		`VOC_OFS_POL: rd_mux = {pol_r[4], 3'h0, pol_r[3:0]};
		`VOC_OFS_DRV: rd_mux = {2'h0, drv_r};
		`VOC_OFS_STAT: rd_mux = {6'h00, audio_locked, video_locked};
		default: rd_mux = 8'h00;
		endcase
	end

	assign data_drive_strength = drv_r[`VOC_DRV_DATA+:2];
	assign clock_drive_strength = drv_r[`VOC_DRV_CLK+:2];
	assign sync_drive_strength = drv_r[`VOC_DRV_SYNC+:2];
	assign crystal_frequency_select = xtal_r;
	assign primary_mode_select = mode_r;
	assign video_standard_select = std_r;

	// link clock is sampled, so it must stay below half of clk
	reg [2:0] lnk_q;
	wire tick = lnk_q[1] & ~lnk_q[2];
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lnk_q <= 3'h0;
		else
			lnk_q <= {lnk_q[1:0], link_clk_pin};
	end

	// deep colour: one pixel per bpc/8 link clocks via remainder accumulator
	reg [4:0] bpc;
	always @* begin
		case (deep_color)
		2'h0: bpc = 5'h08;
		2'h1: bpc = 5'h0a;
		2'h2: bpc = 5'h0c;
		2'h3: bpc = 5'h10;
		default: bpc = 5'h08;
		endcase
	end
	reg [4:0] dc_acc;
	reg [3:0] rep_cnt;
	reg [7:0] div_cnt;
	reg pix_lvl;
	wire [4:0] dc_sum = dc_acc + `VOC_PIX_STEP;
	wire dc_ev = tick && dc_sum >= bpc;
	wire rep_ev = dc_ev && rep_cnt == pix_repeat;
	wire [7:0] div_top = (8'h01 << out_div) - 8'h01;
	wire div_ev = rep_ev && div_cnt == div_top;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dc_acc <= 5'h00;
			rep_cnt <= 4'h0;
			div_cnt <= 8'h00;
			pix_lvl <= 1'b0;
		end else if (tick) begin
			dc_acc <= dc_ev ? dc_sum - bpc : dc_sum;
			if (dc_ev)
				rep_cnt <= rep_ev ? 4'h0 : rep_cnt + 4'h1;
			if (rep_ev)
				div_cnt <= div_ev ? 8'h00 : div_cnt + 8'h01;
			if (div_ev)
				pix_lvl <= ~pix_lvl;
		end
	end

	// video lock: next frame start after pixels run on a stable setup
	reg [5:0] cfg_q;
	reg [8:0] loss_cnt;
	reg pix_seen, vs_d;
	wire cfg_chg = cfg_q != {deep_color, pix_repeat};
	wire frame_go = dec_vs & ~vs_d;
	wire lost = loss_cnt == `VOC_LOSS_CYC;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= 6'h00;
			loss_cnt <= 9'h000;
			pix_seen <= 1'b0;
			vs_d <= 1'b0;
			video_locked <= 1'b0;
		end else begin
			cfg_q <= {deep_color, pix_repeat};
			vs_d <= dec_vs;
			if (tick)
				loss_cnt <= 9'h000;
			else if (!lost)
				loss_cnt <= loss_cnt + 9'h001;
			if (cfg_chg || lost) begin
				pix_seen <= 1'b0;
				video_locked <= 1'b0;
			end else begin
				if (rep_ev)
					pix_seen <= 1'b1;
				if (frame_go && pix_seen)
					video_locked <= 1'b1;
			end
		end
	end

	// audio: NCO adds 2N per link clock and wraps at CTS
	reg [19:0] n_r, cts_r;
	reg [20:0] a_acc;
	reg [17:0] a_tmr;
	reg [4:0] a_evs;
	// one toggle per event puts mclk at link rate times N over CTS;
	// the host must keep 2N at or below CTS
	wire [21:0] a_sum = {1'b0, a_acc} + {1'b0, n_r, 1'b0};
	wire [21:0] a_left = a_sum - {2'h0, cts_r};
	wire a_ev = tick && cts_r != 20'h00000 && a_sum >= {2'h0, cts_r};
	wire a_run = cts_r != 20'h00000;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n_r <= 20'h00000;
			cts_r <= 20'h00000;
			a_acc <= 21'h000000;
			a_tmr <= 18'h00000;
			a_evs <= 5'h00;
			audio_mclk <= 1'b0;
			audio_locked <= 1'b0;
		end else if (acr_valid) begin
			n_r <= acr_n;
			cts_r <= acr_cts;
			if (acr_n != n_r || acr_cts != cts_r) begin
				a_acc <= 21'h000000;
				a_tmr <= 18'h00000;
				a_evs <= 5'h00;
				audio_locked <= 1'b0;
			end
		end else if (a_run) begin
			if (tick)
				a_acc <= a_ev ? a_left[20:0] : a_sum[20:0];
			if (a_ev) begin
				audio_mclk <= ~audio_mclk;
				if (a_evs != `VOC_AUD_SETTLE)
					a_evs <= a_evs + 5'h01;
			end
			if (a_tmr != AUD_LOCK_CYC[17:0] - 18'h00001)
				a_tmr <= a_tmr + 18'h00001;
			// deadline forces lock so it never exceeds 5 ms
			if (a_evs == `VOC_AUD_SETTLE ||
			    a_tmr == AUD_LOCK_CYC[17:0] - 18'h00001)
				audio_locked <= 1'b1;
		end
	end

	// decode path does not depend on mode or standard
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			component_processor_data <= {VID_W{1'b0}};
			component_processor_valid <= 1'b0;
			audio_out <= 1'b0;
			audio_out_valid <= 1'b0;
		end else begin
			component_processor_data <= dec_data;
			component_processor_valid <= dec_valid;
			audio_out <= dec_audio;
			audio_out_valid <= dec_audio_valid;
		end
	end

	voc_out_stage u_pins (
		.clk(clk),
		.rst_n(rst_n),
		.pix_in(pix_lvl),
		.hs_in(dec_hs),
		.vs_in(dec_vs),
		.field_in(dec_field),
		.de_in(dec_de),
		.pol(pol_r),
		.de_field_sel(fsel_r),
		.pixel_clock_out(pixel_clock_out),
		.hsync_out(hsync_out),
		.vertical_sync_shared_pin(vertical_sync_shared_pin),
		.de_out(de_out)
	);
endmodule // voc_top
`default_nettype wire

// *** tb/voc_props.sv ***
// assertion checker for the output configuration block
`timescale 1ns/1ps
`default_nettype none
module voc_props #(
	parameter integer AUD_LOCK_CYC = 200000, // audio lock limit
	parameter integer VID_W = 24 // pixel width
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic link_clk_pin, // link pin
	input wire logic [1:0] deep_color, // depth code
	input wire logic acr_valid, // packet pulse
	input wire logic [VID_W-1:0] dec_data, // video in
	input wire logic dec_valid, // video in valid
	input wire logic dec_vs, // vsync in
	input wire logic dec_audio, // audio in
	input wire logic dec_audio_valid, // audio in valid
	input wire logic [VID_W-1:0] component_processor_data, // video out
	input wire logic component_processor_valid, // video out valid
	input wire logic audio_out, // audio out
	input wire logic audio_out_valid, // audio out valid
	input wire logic [1:0] data_drive_strength, // data drive
	input wire logic [1:0] clock_drive_strength, // clock drive
	input wire logic [1:0] sync_drive_strength, // sync drive
	input wire logic [1:0] crystal_frequency_select, // reference
	input wire logic [3:0] primary_mode_select, // mode
	input wire logic [5:0] video_standard_select, // standard
	input wire logic video_locked, // video lock
	input wire logic audio_locked // audio lock
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [8:0] idle;
	logic [31:0] wt;
	logic armed, last;
	// idle counts cycles since the last pin change, so the sync delay only makes it lenient
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle <= 9'h0;
			wt <= 32'h0;
			armed <= 1'b0;
			last <= 1'b0;
		end else begin
			last <= link_clk_pin;
			idle <= (link_clk_pin != last) ? 9'h0 : idle + {8'h0, ~&idle};
			armed <= armed | acr_valid;
			wt <= (acr_valid || audio_locked) ? 32'h0 : wt + {31'h0, armed};
		end
	end
	a_comp_data: assert property (dec_valid |=> component_processor_valid
		&& component_processor_data == $past(dec_data))
		else $error("video not passed to component path");
	a_comp_idle: assert property (!dec_valid
		|=> !component_processor_valid)
		else $error("component valid without input");
	a_audio_pass: assert property (dec_audio_valid |=> audio_out_valid
		&& audio_out == $past(dec_audio))
		else $error("audio not passed to audio port");
	a_drive_reset: assert property ($rose(rst_n) |->
		data_drive_strength == 2'h2 && clock_drive_strength == 2'h2
		&& sync_drive_strength == 2'h2)
		else $error("drive fields wrong after reset");
	a_mode_reset: assert property ($rose(rst_n) |->
		crystal_frequency_select == 2'h1 && primary_mode_select == 4'h6
		&& video_standard_select == 6'h02)
		else $error("mode fields wrong after reset");
	a_vlock_loss: assert property (!$stable(deep_color) |->
		##[1:3] !video_locked)
		else $error("video lock kept over depth change");
	a_vlock_vs: assert property ($rose(video_locked) |->
		$past(dec_vs) || $past(dec_vs, 2) || $past(dec_vs, 3))
		else $error("video lock not at vsync");
	a_vlock_idle: assert property (idle >= 9'h12c |-> !video_locked)
		else $error("video lock kept without link clock");
	a_alock_time: assert property (armed |-> wt <= AUD_LOCK_CYC + 8)
		else $error("audio lock too late");
endmodule // voc_props
bind voc_top voc_props #(.AUD_LOCK_CYC(AUD_LOCK_CYC), .VID_W(VID_W)) i_props (
	.clk(clk), .rst_n(rst_n), .link_clk_pin(link_clk_pin),
	.deep_color(deep_color), .acr_valid(acr_valid), .dec_data(dec_data),
	.dec_valid(dec_valid), .dec_vs(dec_vs), .dec_audio(dec_audio),
	.dec_audio_valid(dec_audio_valid),
	.component_processor_data(component_processor_data),
	.component_processor_valid(component_processor_valid),
	.audio_out(audio_out), .audio_out_valid(audio_out_valid),
	.data_drive_strength(data_drive_strength),
	.clock_drive_strength(clock_drive_strength),
	.sync_drive_strength(sync_drive_strength),
	.crystal_frequency_select(crystal_frequency_select),
	.primary_mode_select(primary_mode_select),
	.video_standard_select(video_standard_select),
	.video_locked(video_locked), .audio_locked(audio_locked));
`default_nettype wire

// *** tb/voc_sink.sv ***
// downstream video sink: counts pixel clock rising edges
`timescale 1ns/1ps
`default_nettype none
module voc_sink (
	input wire logic clk, // system clock
	input wire logic pix, // pixel clock pin
	input wire logic clr, // zero the count
	output logic [15:0] edges // rising edges seen
);
	logic last = 1'b0;
	always @(posedge clk) begin
		last <= pix;
		if (clr)
			edges <= 16'h0;
		else if (pix && !last)
			edges <= edges + 16'h1;
	end
endmodule // voc_sink
`default_nettype wire

// *** tb/voc_top_bench.sv ***
// self-checking bench for the output configuration block
`timescale 1ns/1ps
`default_nettype none
module voc_top_bench;
	logic clk = 0, rst_n = 0, scl = 1, m = 1, lk = 0, run = 0, clr = 0;
	logic [1:0] dc = 0, od = 0, lc = 0, dds, cds, sds, xs;
	logic [3:0] pr = 0, pm;
	logic [5:0] sd;
	logic [19:0] an = 0, ac = 0;
	logic av = 0, hs = 0, vs = 0, fl = 0, de = 0, dv = 0, au = 0, auv = 0;
	logic [23:0] dd = 0;
	logic so, oe, pco, hso, vso, deo, vl, al, v, mc;
	logic [7:0] r, p;
	logic [15:0] ed, me;
	int fails = 0, comparisons = 0;
	wire sda = oe ? so : m;
	voc_top #(.DEV_ADDR(7'h4c), .AUD_LOCK_CYC(200)) i_dut (
		.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
		.sda_out(so), .sda_oe(oe), .link_clk_pin(lk), .deep_color(dc),
		.pix_repeat(pr), .out_div(od), .acr_n(an), .acr_cts(ac),
		.acr_valid(av), .dec_data(dd), .dec_valid(dv), .dec_hs(hs),
		.dec_vs(vs), .dec_field(fl), .dec_de(de), .dec_audio(au),
		.dec_audio_valid(auv), .component_processor_data(),
		.component_processor_valid(), .audio_out(), .audio_out_valid(),
		.audio_mclk(mc), .pixel_clock_out(pco), .hsync_out(hso),
		.vertical_sync_shared_pin(vso), .de_out(deo),
		.data_drive_strength(dds), .clock_drive_strength(cds),
		.sync_drive_strength(sds), .crystal_frequency_select(xs),
		.primary_mode_select(pm), .video_standard_select(sd),
		.video_locked(vl), .audio_locked(al));
	voc_sink i_sink (.clk(clk), .pix(pco), .clr(clr), .edges(ed));
	voc_sink i_msink (.clk(clk), .pix(mc), .clr(clr), .edges(me));
	initial forever #12.5 clk = ~clk;
	// link pin well under the sync limit: one tick per six clocks
	always @(posedge clk) begin
		if (run) begin
			lc <= (lc == 2'h2) ? 2'h0 : lc + 2'h1;
			if (lc == 2'h2)
				lk <= ~lk;
		end
	end
	function automatic int exp_edges(int t, int d, int rp, int o);
		int bpc;
		bpc = (d == 3) ? 16 : 8 + 2 * d;
		return t * 8 / bpc / (rp + 1) / (1 << o) / 2;
	endfunction
	// rising edges of an mclk at link rate times N over CTS
	function automatic int exp_mclk(int t, int n, int c);
		return t * n / c;
	endfunction
	task q(input int n);
		repeat (n) @(posedge clk);
	endtask
	task burst;
		repeat (40) begin
			{dv, au, auv} <= 3'($urandom);
			dd <= 24'($urandom);
			q(1);
		end
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// scl high and low both 300 ns, above the slave's sync margin
	task bt(input logic b, output logic s);
		m <= b;
		q(6);
		scl <= 1;
		q(6);
		#1 s = sda;
		q(6);
		scl <= 0;
		q(6);
	endtask
	task st;
		m <= 1;
		q(6);
		scl <= 1;
		q(6);
		m <= 0;
		q(6);
		scl <= 0;
		q(6);
	endtask
	task sp;
		m <= 0;
		q(6);
		scl <= 1;
		q(6);
		m <= 1;
		q(6);
	endtask
	task wb(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bt(d[i], s);
		bt(1, s);
		chk("ack", 0, s);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		st;
		wb(8'h98);
		wb(a);
		wb(d);
		sp;
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		logic s;
		st;
		wb(8'h98);
		wb(a);
		st;
		wb(8'h99);
		for (int i = 7; i >= 0; i--)
			bt(1, r[i]);
		bt(1, s);
		sp;
		chk($sformatf("reg %h", a), e, r);
	endtask
	task final_report;
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		final_report;
	end
	initial begin
		void'($urandom(75569));
		q(5);
		rst_n <= 1;
		q(3);
		rc(8'h00, 8'h02);
		rc(8'h01, 8'h06);
		rc(8'h04, 8'h02);
		rc(8'h05, 8'h00);
		rc(8'h06, 8'h80);
		rc(8'h14, 8'h2a);
		rc(8'h30, 8'h00);
		for (int k = 1; k < 4; k++) begin
			p = 8'(k * 16 + (k % 3 + 1) * 4 + (k + 1) % 3 + 1);
			wr(8'h14, p);
			chk("data drive", p[5:4], dds);
			chk("clock drive", p[3:2], cds);
			chk("sync drive", p[1:0], sds);
			rc(8'h14, p);
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'h04, 8'(c * 2));
			chk("crystal", c, xs);
		end
		wr(8'h01, 8'h05);
		chk("mode", 4'h5, pm);
		p = 8'($urandom % 4);
		wr(8'h00, p);
		rc(8'h00, p);
		chk("standard", p, sd);
		for (int i = 0; i < 8; i++) begin
			p = {i[0], 3'h0, i[1] ^ i[2], i[2], i[1], 1'b0};
			wr(8'h06, p);
			wr(8'h05, {3'h0, i[0] ^ i[2], 4'h0});
			repeat (4) begin
				{hs, vs, fl, de} <= 4'($urandom);
				q(2);
				chk("hsync pin", hs ^ !p[1], hso);
				chk("vertical pin", (p[7] ? vs : fl) ^ !p[2], vso);
				chk("enable pin", (i[0] ^ i[2] ? fl : de) ^ p[3], deo);
			end
		end
		{hs, vs} <= 2'h0;
		q(4);
		v = pco;
		wr(8'h06, 8'h81);
		chk("pixel pin", !v, pco);
		chk("hsync pin", 1, hso);
		wr(8'h06, 8'h80);
		chk("pixel pin", v, pco);
		run <= 1;
		for (int j = 0; j < 3; j++) begin
			{dc, pr, od} <= (j == 0) ? 8'h00 : (j == 1) ?
				{2'h2, 4'h1, 2'h1} : {2'h3, 4'h0, 2'h2};
			q(60);
			clr <= 1;
			q(1);
			clr <= 0;
			q(720);
			r = 8'(exp_edges(120, dc, pr, od));
			chk("pixel edges", 1, ed + 1 >= r && ed <= r + 1);
		end
		vs <= 1;
		q(4);
		vs <= 0;
		q(4);
		chk("video lock", 1, vl);
		dc <= 2'h1;
		q(4);
		chk("video lock", 0, vl);
		q(40);
		vs <= 1;
		q(4);
		vs <= 0;
		q(4);
		chk("video lock", 1, vl);
		// 2N stays at or below CTS so mclk can follow the link ticks
		an <= 20'h400 + 20'($urandom % 1024);
		ac <= 20'h1000 + 20'($urandom % 4096);
		av <= 1;
		q(1);
		av <= 0;
		for (int i = 0; i < 400 && al !== 1; i++)
			q(1);
		chk("audio lock", 1, al);
		clr <= 1;
		q(1);
		clr <= 0;
		q(720);
		r = 8'(exp_mclk(120, an, ac));
		chk("mclk edges", 1, me + 1 >= r && me <= r + 1);
		burst;
		run <= 0;
		q(300);
		chk("video lock", 0, vl);
		wr(8'h01, 8'h06);
		wr(8'h00, 8'h02);
		chk("mode", 4'h6, pm);
		chk("standard", 6'h02, sd);
		burst;
		final_report;
	end
endmodule // voc_top_bench
`default_nettype wire
